/* File: src/pio_pkg.sv */
/*
 * Constants and types of the parallel port block: port slots, line masks,
 * register indices and bus answer codes.
 * Assumes a 32-bit AXI4-Lite register bus with a 12-bit byte address.
 */
package pio_pkg;

	// ****************************************
	// Port geometry
	// ****************************************
	localparam int SLOT = 16;
	localparam int NPORT = 13;
	localparam int LINES_MAX = 118;
	typedef logic [SLOT-1:0] pio_word_t;
	typedef pio_word_t [NPORT-1:0] pio_bank_t;
	localparam logic [3:0] PORTS = 4'hD;
	localparam logic [3:0] SLOT_P15 = 4'hC;
	localparam logic [3:0] SLOT_P5 = 4'h5;
	// Existing lines per slot; slot 12 is port 15.
	localparam pio_bank_t LINE_MASK = {16'h00FF, 16'h003F, 16'hFFFF, 16'h00FF,
		16'h007F, 16'h001F, 16'h000F, 16'hFFFF, 16'h00FF, 16'h00FF, 16'h1FFF,
		16'h00FF, 16'h00FF};
	// Lines that can drive; the two input-only ports are zero.
	localparam pio_bank_t DRV_MASK = {16'h0000, 16'h003F, 16'hFFFF, 16'h00FF,
		16'h007F, 16'h001F, 16'h000F, 16'h0000, 16'h00FF, 16'h00FF, 16'h1FFF,
		16'h00FF, 16'h00FF};
	localparam pio_word_t CFG_RST = 16'h0000;

	// ****************************************
	// Register map
	// ****************************************
	localparam int ADDR_W = 12;
	localparam int PORT_LSB = 6;
	localparam int REG_LSB = 2;
	localparam int MOD_LSB = 16;
	localparam logic [3:0] REG_OUT = 4'h0;
	localparam logic [3:0] REG_MOD = 4'h1;
	localparam logic [3:0] REG_DIR = 4'h2;
	localparam logic [3:0] REG_OD = 4'h3;
	localparam logic [3:0] REG_PULL = 4'h4;
	localparam logic [3:0] REG_EDGE = 4'h5;
	localparam logic [3:0] REG_DRV = 4'h6;
	localparam logic [3:0] REG_ALT = 4'h7;
	localparam logic [3:0] REG_IN = 4'h8;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

/* File: src/pio_port.sv */
/*
 * Parallel port block: per-line direction, open-drain, pull, edge and drive
 * settings, alternate function takeover and synchronised input sampling,
 * all reached over AXI4-Lite.
 * Assumes pad cells that resolve data, enable and pull into the real pin,
 * and peripherals that present one data and enable value for every line.
 */
// The implementer's own choices: register access over AXI4-Lite and the register addresses.
// Overview of operation
// - At most 118 lines, 11 bidirectional, 2 input.
// - Each line is written alone through a mask.
// - Per-line direction, open-drain, pull, edge, drive settings.
// - Input lines have their driver switched off.
// - Reset makes every line an input, pulls off.
// - Alternate functions are selectable on any line; the code allows them only on the 11 bidirectional ports.
// - Lines without alternate function are software driven.
// - Port 15: eight input lines, timer use.
`timescale 1ns/1ps
module pio_port
	import pio_pkg::*;
(
	input wire logic CLK_SYS_IN,
	input wire logic SYS_RST_IN,
	input wire logic [ADDR_W-1:0] AXI_AWADDR_IN,
	input wire logic AXI_AWVALID_IN,
	output logic AXI_AWREADY_OUT,
	input wire logic [31:0] AXI_WDATA_IN,
	input wire logic [3:0] AXI_WSTRB_IN,
	input wire logic AXI_WVALID_IN,
	output logic AXI_WREADY_OUT,
	output logic [1:0] AXI_BRESP_OUT,
	output logic AXI_BVALID_OUT,
	input wire logic AXI_BREADY_IN,
	input wire logic [ADDR_W-1:0] AXI_ARADDR_IN,
	input wire logic AXI_ARVALID_IN,
	output logic AXI_ARREADY_OUT,
	output logic [31:0] AXI_RDATA_OUT,
	output logic [1:0] AXI_RRESP_OUT,
	output logic AXI_RVALID_OUT,
	input wire logic AXI_RREADY_IN,
	input wire pio_bank_t PAD_LEVEL_IN,
	output pio_bank_t PAD_DATA_OUT,
	output pio_bank_t PAD_OE_OUT,
	output pio_bank_t PAD_PULL_OUT,
	output pio_bank_t PAD_EDGE_OUT,
	output pio_bank_t PAD_DRIVE_OUT,
	input wire pio_bank_t ALT_DATA_IN,
	input wire pio_bank_t ALT_OE_IN,
	output pio_bank_t ALT_SEL_OUT,
	output pio_bank_t LINE_LEVEL_OUT
);

	// ****************************************
	// Storage
	// ****************************************
	pio_bank_t out_q, dir_q, od_q, pull_q, edge_q, drv_q, alt_q;
	pio_bank_t sync1, sync2, sync3, level_q;
	logic [ADDR_W-1:0] aw_addr;
	logic [31:0] w_data;
	logic [3:0] w_strb;
	logic aw_full, w_full;

	// ****************************************
	// Helper functions
	// ****************************************
	// Byte-lane merge of bus data into a stored word.
	function automatic pio_word_t merge(input pio_word_t old,
		input logic [31:0] d, input logic [3:0] s);
		merge = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
	endfunction

	// Address decode: inside the map, existing port, existing register.
	function automatic logic addr_ok(input logic [ADDR_W-1:0] a);
		addr_ok = (a[ADDR_W-1:PORT_LSB+4] == '0) &&
			(a[PORT_LSB+:4] < PORTS) && (a[REG_LSB+:4] <= REG_IN);
	endfunction

	// Present value of register r of port slot p.
	function automatic pio_word_t rd_sel(input logic [3:0] p, input logic [3:0] r);
		rd_sel = CFG_RST;
		if (r == REG_OUT || r == REG_MOD) begin
			rd_sel = out_q[p];
		end else if (r == REG_DIR) begin
			rd_sel = dir_q[p];
		end else if (r == REG_OD) begin
			rd_sel = od_q[p];
		end else if (r == REG_PULL) begin
			rd_sel = pull_q[p];
		end else if (r == REG_EDGE) begin
			rd_sel = edge_q[p];
		end else if (r == REG_DRV) begin
			rd_sel = drv_q[p];
		end else if (r == REG_ALT) begin
			rd_sel = alt_q[p];
		end else if (r == REG_IN) begin
			rd_sel = level_q[p];
		end
	endfunction

	// ****************************************
	// Write channel
	// ****************************************
	// Address and data are held separately, so either may come first.
	wire logic aw_take = AXI_AWVALID_IN && AXI_AWREADY_OUT;
	wire logic w_take = AXI_WVALID_IN && AXI_WREADY_OUT;
	wire logic wr_go = aw_full && w_full && !AXI_BVALID_OUT;
	wire logic next_aw_full = aw_take || (aw_full && !wr_go);
	wire logic next_w_full = w_take || (w_full && !wr_go);
	wire logic next_bvalid = wr_go || (AXI_BVALID_OUT && !AXI_BREADY_IN);
	wire logic [3:0] wp = aw_addr[PORT_LSB+:4];
	wire logic [3:0] wr_reg = aw_addr[REG_LSB+:4];
	wire logic wr_ok = addr_ok(aw_addr);
	wire pio_word_t wr_word = merge(rd_sel(wp, wr_reg), w_data, w_strb) & DRV_MASK[wp];
	wire pio_word_t mod_mask = w_data[MOD_LSB+:SLOT] & {{8{w_strb[3]}}, {8{w_strb[2]}}};
	wire pio_word_t mod_word = ((out_q[wp] & ~mod_mask) | (w_data[SLOT-1:0] & mod_mask))
		& DRV_MASK[wp];

	// Bus handshake state of the write side.
	always_ff @(posedge CLK_SYS_IN) begin
		if (SYS_RST_IN) begin
			aw_full <= 1'b0;
			w_full <= 1'b0;
			AXI_AWREADY_OUT <= 1'b0;
			AXI_WREADY_OUT <= 1'b0;
			AXI_BVALID_OUT <= 1'b0;
			AXI_BRESP_OUT <= RESP_OKAY;
		end else begin
			aw_full <= next_aw_full;
			w_full <= next_w_full;
			AXI_AWREADY_OUT <= !next_aw_full;
			AXI_WREADY_OUT <= !next_w_full;
			AXI_BVALID_OUT <= next_bvalid;
			if (wr_go) begin
				AXI_BRESP_OUT <= wr_ok ? RESP_OKAY : RESP_SLVERR;
			end
		end
	end

	// Captures the write payloads as they are taken.
	always_ff @(posedge CLK_SYS_IN) begin
		if (aw_take) begin
			aw_addr <= AXI_AWADDR_IN;
		end
		if (w_take) begin
			w_data <= AXI_WDATA_IN;
			w_strb <= AXI_WSTRB_IN;
		end
	end

	// ****************************************
	// Line settings
	// ****************************************
	// Stores one register word; input-only ports keep zero settings.
	always_ff @(posedge CLK_SYS_IN) begin
		if (SYS_RST_IN) begin
			out_q <= '0;
			dir_q <= '0;
			od_q <= '0;
			pull_q <= '0;
			edge_q <= '0;
			drv_q <= '0;
			alt_q <= '0;
		end else if (wr_go && wr_ok) begin
			unique case (wr_reg)
				REG_MOD: out_q[wp] <= mod_word;
				REG_OUT: out_q[wp] <= wr_word;
				REG_DIR: dir_q[wp] <= wr_word;
				REG_OD: od_q[wp] <= wr_word;
				REG_PULL: pull_q[wp] <= wr_word;
				REG_EDGE: edge_q[wp] <= wr_word;
				REG_DRV: drv_q[wp] <= wr_word;
				REG_ALT: alt_q[wp] <= wr_word;
				default: ;
			endcase
		end
	end

	// ****************************************
	// Read channel
	// ****************************************
	// Read handshake and the word that the offered address selects.
	wire logic ar_take = AXI_ARVALID_IN && AXI_ARREADY_OUT;
	wire logic next_rvalid = ar_take || (AXI_RVALID_OUT && !AXI_RREADY_IN);
	wire logic rd_ok = addr_ok(AXI_ARADDR_IN);
	wire pio_word_t rd_word = rd_ok ?
		rd_sel(AXI_ARADDR_IN[PORT_LSB+:4], AXI_ARADDR_IN[REG_LSB+:4]) : CFG_RST;

	// One read at a time; the address is refused while an answer waits.
	always_ff @(posedge CLK_SYS_IN) begin
		if (SYS_RST_IN) begin
			AXI_RVALID_OUT <= 1'b0;
			AXI_ARREADY_OUT <= 1'b0;
			AXI_RDATA_OUT <= '0;
			AXI_RRESP_OUT <= RESP_OKAY;
		end else begin
			AXI_RVALID_OUT <= next_rvalid;
			AXI_ARREADY_OUT <= !next_rvalid;
			if (ar_take) begin
				AXI_RDATA_OUT <= {16'h0000, rd_word};
				AXI_RRESP_OUT <= rd_ok ? RESP_OKAY : RESP_SLVERR;
			end
		end
	end

	// ****************************************
	// Pad drive
	// ****************************************
	// software value unless alternate
	// peripheral value and enable take over
	wire pio_bank_t drive_val = (alt_q & ALT_DATA_IN) | (~alt_q & out_q);
	wire pio_bank_t drive_en = (alt_q & ALT_OE_IN) | (~alt_q & dir_q);
	wire pio_bank_t next_oe = drive_en & ~(od_q & drive_val) & DRV_MASK;
	wire pio_bank_t next_data = drive_val & ~od_q & DRV_MASK;

	// Registers every pad control; open drain only ever pulls low.
	always_ff @(posedge CLK_SYS_IN) begin
		if (SYS_RST_IN) begin
			PAD_OE_OUT <= '0;
			PAD_DATA_OUT <= '0;
			PAD_PULL_OUT <= '0;
			PAD_EDGE_OUT <= '0;
			PAD_DRIVE_OUT <= '0;
			ALT_SEL_OUT <= '0;
		end else begin
			PAD_OE_OUT <= next_oe;
			PAD_DATA_OUT <= next_data;
			PAD_PULL_OUT <= pull_q;
			PAD_EDGE_OUT <= edge_q;
			PAD_DRIVE_OUT <= drv_q;
			ALT_SEL_OUT <= alt_q;
		end
	end

	// ****************************************
	// Input sampling
	// ****************************************
	// three-stage synchroniser
	wire pio_bank_t agree = ~(sync2 ^ sync3);
	wire pio_bank_t next_level = ((agree & sync2) | (~agree & level_q)) & LINE_MASK;

	// A level counts only once the second and third stages agree.
	always_ff @(posedge CLK_SYS_IN) begin
		if (SYS_RST_IN) begin
			sync1 <= '0;
			sync2 <= '0;
			sync3 <= '0;
			level_q <= '0;
		end else begin
			sync1 <= PAD_LEVEL_IN;
			sync2 <= sync1;
			sync3 <= sync2;
			level_q <= next_level;
		end
	end

	assign LINE_LEVEL_OUT = level_q;

	// ****************************************
	// Checks
	// ****************************************
	default clocking cb @(posedge CLK_SYS_IN);
	endclocking
	default disable iff (SYS_RST_IN);

	// Watches an input-only port, since floating lines elsewhere never hold still.
	// The chain must have run four edges clear of reset before it can be full.
	sequence s_pin_steady;
		$stable(PAD_LEVEL_IN[SLOT_P5]) [*4] ##0 !$past(SYS_RST_IN, 4);
	endsequence

	sequence s_mod_write;
		wr_go && wr_ok && wr_reg == REG_MOD;
	endsequence

	a_width_lines: assert property (
		(PAD_OE_OUT & ~DRV_MASK) == '0 && (LINE_LEVEL_OUT & ~LINE_MASK) == '0)
		else $error("Line outside the port widths is active.");

	a_mod_one_bit: assert property (s_mod_write |=>
		((out_q[$past(wp)] ^ $past(out_q[wp])) & ~$past(mod_mask)) == '0)
		else $error("Masked modify changed an unmasked line.");

	a_dir_store: assert property (wr_go && wr_ok && wr_reg == REG_DIR |=>
		dir_q[$past(wp)] == $past(wr_word))
		else $error("Direction write was not stored.");

	a_input_hiz: assert property (
		##1 (($past(~dir_q & ~alt_q) & PAD_OE_OUT) == '0))
		else $error("Input line is being driven.");

	a_reset_inputs: assert property ($past(SYS_RST_IN) |->
		PAD_OE_OUT == '0 && PAD_PULL_OUT == '0)
		else $error("Line driven or pulled right after reset.");

	a_alt_drive: assert property (
		##1 (((PAD_DATA_OUT ^ $past(ALT_DATA_IN)) & $past(alt_q & ~od_q & DRV_MASK)) == '0))
		else $error("Alternate line does not carry peripheral data.");

	a_gpio_drive: assert property (
		##1 (((PAD_DATA_OUT ^ $past(out_q)) & $past(~alt_q & ~od_q & DRV_MASK)) == '0))
		else $error("Software line does not carry its output value.");

	a_p15_input: assert property (
		PAD_OE_OUT[SLOT_P15] == '0 && LINE_LEVEL_OUT[SLOT_P15][SLOT-1:8] == '0)
		else $error("Port 15 drives or exceeds eight lines.");

	a_sync_level: assert property (s_pin_steady |->
		LINE_LEVEL_OUT[SLOT_P5] == (PAD_LEVEL_IN[SLOT_P5] & LINE_MASK[SLOT_P5]))
		else $error("Steady pin level not seen after synchroniser.");

endmodule // pio_port

/* File: test/pio_pads.sv */
/*
 * Pin model for the parallel port: resolves every pin from the block's drive,
 * an outside driver and the pull enable.
 * Assumes pulls pull up and a floating pin shows the inverse of its last level.
 */
`timescale 1ns/1ps
module pio_pads
	import pio_pkg::*;
(
	input wire logic clk_in,
	input wire pio_bank_t data_in,
	input wire pio_bank_t oe_in,
	input wire pio_bank_t pull_in,
	input wire pio_bank_t ext_in,
	input wire pio_bank_t ext_oe_in,
	output pio_bank_t level_out
);
	pio_bank_t last = '0;

	// The block wins, then the outside driver, then the pull or a wandering level.
	assign level_out = (oe_in & data_in) | (~oe_in & ext_oe_in & ext_in)
		| (~oe_in & ~ext_oe_in & (pull_in | ~last));

	// Remembers the level so that a floating pin never holds still.
	always_ff @(posedge clk_in) begin
		last <= level_out;
	end
endmodule // pio_pads

/* File: test/pio_port_test.sv */
/*
 * Self-checking bench of the parallel port block: register table, pad drive,
 * alternate takeover, input synchroniser and reset.
 * Assumes the pin model in pio_pads and an AXI4-Lite master of its own.
 */
`timescale 1ns/1ps
module pio_port_test import pio_pkg::*;;
	typedef struct packed {logic [11:0] wa; logic [31:0] wd; logic [3:0] ws;
		logic [11:0] ra; logic [31:0] rd; logic [1:0] rs;} pio_row_t;
	logic CLK_SYS_IN = 1'h0;
	logic SYS_RST_IN = 1'h1;
	logic [ADDR_W-1:0] AXI_AWADDR_IN = '0, AXI_ARADDR_IN = '0;
	logic [31:0] AXI_WDATA_IN = '0, AXI_RDATA_OUT, data;
	logic [3:0] AXI_WSTRB_IN = '0;
	logic AXI_AWVALID_IN = 1'h0, AXI_WVALID_IN = 1'h0, AXI_BREADY_IN = 1'h0;
	logic AXI_ARVALID_IN = 1'h0, AXI_RREADY_IN = 1'h0;
	logic AXI_AWREADY_OUT, AXI_WREADY_OUT, AXI_BVALID_OUT, AXI_ARREADY_OUT, AXI_RVALID_OUT;
	logic [1:0] AXI_BRESP_OUT, AXI_RRESP_OUT, resp;
	pio_bank_t PAD_LEVEL_IN, PAD_DATA_OUT, PAD_OE_OUT, PAD_PULL_OUT, PAD_EDGE_OUT;
	pio_bank_t PAD_DRIVE_OUT, ALT_SEL_OUT, LINE_LEVEL_OUT, ALT_DATA_IN = '0, ALT_OE_IN = '0;
	pio_bank_t ext = '0, ext_oe = '0;
	int err_count = 0, cmp_count = 0;
	// Writes and read-backs, the read answer code equal to the write's.
	pio_row_t rows [10] = '{
		'{12'h008, 32'h0000FFFF, 4'h3, 12'h008, 32'h000000FF, RESP_OKAY},
		'{12'h148, 32'h0000FFFF, 4'h3, 12'h148, 32'h00000000, RESP_OKAY},
		'{12'h308, 32'h0000FFFF, 4'h3, 12'h308, 32'h00000000, RESP_OKAY},
		'{12'h280, 32'h0000A5A5, 4'h3, 12'h280, 32'h0000A5A5, RESP_OKAY},
		'{12'h284, 32'h00F00FFF, 4'hF, 12'h280, 32'h0000A5F5, RESP_OKAY},
		'{12'h280, 32'h00001234, 4'h1, 12'h280, 32'h0000A534, RESP_OKAY},
		'{12'h094, 32'h0000FFFF, 4'h3, 12'h094, 32'h00001FFF, RESP_OKAY},
		'{12'h2D8, 32'h0000FFFF, 4'h3, 12'h2D8, 32'h0000003F, RESP_OKAY},
		'{12'h020, 32'h0000FFFF, 4'h3, 12'h008, 32'h000000FF, RESP_OKAY},
		'{12'h400, 32'h0000FFFF, 4'h3, 12'h400, 32'h00000000, RESP_SLVERR}};

	// Clock, block and pin model.
	always #20 CLK_SYS_IN = ~CLK_SYS_IN;
	pio_port dut (.CLK_SYS_IN(CLK_SYS_IN), .SYS_RST_IN(SYS_RST_IN),
		.AXI_AWADDR_IN(AXI_AWADDR_IN), .AXI_AWVALID_IN(AXI_AWVALID_IN),
		.AXI_AWREADY_OUT(AXI_AWREADY_OUT), .AXI_WDATA_IN(AXI_WDATA_IN),
		.AXI_WSTRB_IN(AXI_WSTRB_IN), .AXI_WVALID_IN(AXI_WVALID_IN),
		.AXI_WREADY_OUT(AXI_WREADY_OUT), .AXI_BRESP_OUT(AXI_BRESP_OUT),
		.AXI_BVALID_OUT(AXI_BVALID_OUT), .AXI_BREADY_IN(AXI_BREADY_IN),
		.AXI_ARADDR_IN(AXI_ARADDR_IN), .AXI_ARVALID_IN(AXI_ARVALID_IN),
		.AXI_ARREADY_OUT(AXI_ARREADY_OUT), .AXI_RDATA_OUT(AXI_RDATA_OUT),
		.AXI_RRESP_OUT(AXI_RRESP_OUT), .AXI_RVALID_OUT(AXI_RVALID_OUT),
		.AXI_RREADY_IN(AXI_RREADY_IN), .PAD_LEVEL_IN(PAD_LEVEL_IN),
		.PAD_DATA_OUT(PAD_DATA_OUT), .PAD_OE_OUT(PAD_OE_OUT), .PAD_PULL_OUT(PAD_PULL_OUT),
		.PAD_EDGE_OUT(PAD_EDGE_OUT), .PAD_DRIVE_OUT(PAD_DRIVE_OUT),
		.ALT_DATA_IN(ALT_DATA_IN), .ALT_OE_IN(ALT_OE_IN), .ALT_SEL_OUT(ALT_SEL_OUT),
		.LINE_LEVEL_OUT(LINE_LEVEL_OUT));
	pio_pads pads (.clk_in(CLK_SYS_IN), .data_in(PAD_DATA_OUT), .oe_in(PAD_OE_OUT),
		.pull_in(PAD_PULL_OUT), .ext_in(ext), .ext_oe_in(ext_oe), .level_out(PAD_LEVEL_IN));

	// Prints the counts and the verdict, then stops.
	task automatic end_sim();
		$display("comparisons %0d, mismatches %0d", cmp_count, err_count);
		if (err_count == 0 && cmp_count > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask

	// Compares one value and counts it.
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			err_count++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	// A wait that ran out is counted and ends the run.
	task automatic timeout();
		err_count++;
		$display("wrong value at %0t: seen %h expected %h", $time, 1'h0, 1'h1);
		end_sim();
	endtask

	// One AXI4-Lite write; the answer code lands in resp.
	task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
		logic pa, pw;
		int n;
		pa = 1'h1;
		pw = 1'h1;
		@(posedge CLK_SYS_IN);
		AXI_AWADDR_IN <= a;
		AXI_WDATA_IN <= d;
		AXI_WSTRB_IN <= s;
		AXI_AWVALID_IN <= 1'h1;
		AXI_WVALID_IN <= 1'h1;
		AXI_BREADY_IN <= 1'h1;
		for (n = 0; n < 50 && AXI_BVALID_OUT !== 1'h1; n++) begin
			@(posedge CLK_SYS_IN);
			if (pa && AXI_AWREADY_OUT === 1'h1) begin
				pa = 1'h0;
				AXI_AWVALID_IN <= 1'h0;
			end
			if (pw && AXI_WREADY_OUT === 1'h1) begin
				pw = 1'h0;
				AXI_WVALID_IN <= 1'h0;
			end
		end
		resp = AXI_BRESP_OUT;
		AXI_BREADY_IN <= 1'h0;
		if (n == 50) timeout();
	endtask

	// One AXI4-Lite read; the word lands in data, the answer code in resp.
	task automatic rd(input logic [11:0] a);
		int n;
		@(posedge CLK_SYS_IN);
		AXI_ARADDR_IN <= a;
		AXI_ARVALID_IN <= 1'h1;
		AXI_RREADY_IN <= 1'h1;
		for (n = 0; n < 50 && AXI_RVALID_OUT !== 1'h1; n++) begin
			@(posedge CLK_SYS_IN);
			if (AXI_ARREADY_OUT === 1'h1) AXI_ARVALID_IN <= 1'h0;
		end
		data = AXI_RDATA_OUT;
		resp = AXI_RRESP_OUT;
		AXI_RREADY_IN <= 1'h0;
		if (n == 50) timeout();
	endtask

	// Lets k edges pass and their updates land.
	task automatic settle(input int k);
		repeat (k) @(posedge CLK_SYS_IN);
		#1;
	endtask

	// Holds reset, releases it and checks that every line is an undriven input.
	task automatic rst_chk();
		@(posedge CLK_SYS_IN);
		SYS_RST_IN <= 1'h1;
		settle(5);
		chk({31'h0, PAD_OE_OUT !== '0}, 32'h0);
		chk({31'h0, PAD_PULL_OUT !== '0}, 32'h0);
		@(posedge CLK_SYS_IN);
		SYS_RST_IN <= 1'h0;
		rd(12'h008);
		chk(data, 32'h0);
		$display("reset test done");
	endtask

	// Main sequence: reset check first, then table rows, then the awkward cases.
	initial begin
		ext_oe[SLOT_P5] = 16'hFFFF;
		rst_chk();
		for (int i = 0; i < 10; i++) begin
			wr(rows[i].wa, rows[i].wd, rows[i].ws);
			chk(resp, rows[i].rs);
			rd(rows[i].ra);
			chk(data, rows[i].rd);
			chk(resp, rows[i].rs);
		end
		$display("table test done");
		wr(12'h000, 32'h000000A5, 4'h3);
		settle(1);
		chk(PAD_OE_OUT[0], 32'h00FF);
		chk(PAD_DATA_OUT[0], 32'h00A5);
		chk(PAD_OE_OUT[10], 32'h0);
		chk(PAD_EDGE_OUT[2], 32'h1FFF);
		chk(PAD_DRIVE_OUT[11], 32'h003F);
		settle(5);
		chk(LINE_LEVEL_OUT[0], 32'h00A5);
		rd(12'h020);
		chk(data, 32'h00A5);
		ALT_DATA_IN[0] <= 16'h0003;
		ALT_OE_IN[0] <= 16'h0005;
		wr(12'h00C, 32'h00000001, 4'h3);
		wr(12'h010, 32'h000000FF, 4'h3);
		wr(12'h01C, 32'h0000000F, 4'h3);
		settle(1);
		chk(PAD_OE_OUT[0], 32'h00F4);
		chk(PAD_DATA_OUT[0], 32'h00A2);
		chk(ALT_SEL_OUT[0], 32'h000F);
		chk(PAD_PULL_OUT[0], 32'h00FF);
		$display("drive test done");
		@(posedge CLK_SYS_IN);
		ext[SLOT_P5] <= 16'h1234;
		settle(3);
		chk(LINE_LEVEL_OUT[SLOT_P5], 32'h0);
		settle(1);
		chk(LINE_LEVEL_OUT[SLOT_P5], 32'h1234);
		$display("sync test done");
		rst_chk();
		end_sim();
	end
endmodule // pio_port_test
